// File: common/src_det_pkg.sv
package src_det_pkg;
   // wishbone register map (byte addresses)
   localparam logic [7:0] ADDR_CTRL   = 8'h00;
   localparam logic [7:0] ADDR_EXTERNAL_CURRENT_LIMIT_PIN   = 8'h04;
   localparam logic [7:0] ADDR_VLIM   = 8'h08;
   localparam logic [7:0] ADDR_STATUS = 8'h0c;
   localparam logic [7:0] ADDR_EFF    = 8'h10;
   // ctrl fields
   localparam int CTRL_AUTO  = 0;
   localparam int CTRL_FORCE = 1;
   localparam int CTRL_VEND  = 2;
   localparam int CTRL_HVP   = 3;
   localparam int CTRL_ABS   = 4;
   localparam logic [4:0] CTRL_RST = 5'h0d;
   // status fields
   localparam int ST_GOOD  = 0;
   localparam int ST_PG    = 1;
   localparam int ST_PORT  = 2;
   localparam int ST_TYPE  = 3;
   localparam int ST_BIAS  = 6;
   localparam int ST_CONV  = 7;
   localparam int ST_STATE = 8;
   // current limit codes, 50 mA per step
   localparam logic [6:0] EXTERNAL_CURRENT_LIMIT_PIN_RST  = 7'h0a;
   localparam logic [6:0] EXTERNAL_CURRENT_LIMIT_PIN_SDP  = 7'h0a;
   localparam logic [6:0] EXTERNAL_CURRENT_LIMIT_PIN_CDP  = 7'h1e;
   localparam logic [6:0] EXTERNAL_CURRENT_LIMIT_PIN_DCP  = 7'h41;
   localparam logic [6:0] EXTERNAL_CURRENT_LIMIT_PIN_HV   = 7'h1e;
   localparam logic [6:0] EXTERNAL_CURRENT_LIMIT_PIN_UNK  = 7'h0a;
   localparam logic [6:0] EXTERNAL_CURRENT_LIMIT_PIN_DIV1 = 7'h2a;
   localparam logic [6:0] EXTERNAL_CURRENT_LIMIT_PIN_DIV2 = 7'h28;
   localparam logic [6:0] EXTERNAL_CURRENT_LIMIT_PIN_DIV3 = 7'h14;
   localparam logic [6:0] EXTERNAL_CURRENT_LIMIT_PIN_DIV4 = 7'h30;
   // input type codes
   localparam logic [2:0] TYPE_NONE = 3'h0;
   localparam logic [2:0] TYPE_SDP  = 3'h1;
   localparam logic [2:0] TYPE_CDP  = 3'h2;
   localparam logic [2:0] TYPE_DCP  = 3'h3;
   localparam logic [2:0] TYPE_HV   = 3'h4;
   localparam logic [2:0] TYPE_UNK  = 3'h5;
   localparam logic [2:0] TYPE_DIV  = 3'h6;
   // voltage limit codes, 100 mV per step
   localparam logic [7:0] VLIM_MIN  = 8'h27;
   localparam logic [7:0] VLIM_MAX  = 8'h8c;
   localparam logic [7:0] VLIM_RST  = 8'h2c;
   localparam logic [7:0] VLIM_LO   = 8'h2c;
   localparam logic [7:0] VLIM_HI   = 8'h50;
   // timing
   localparam int CLK_KHZ      = 40000;
   localparam int BIAS_DLY_MS  = 220;
   localparam int RETRY_MS     = 2000;
   localparam int DCD_MS       = 500;
   localparam int QUAL_MS      = 10;
   localparam int HV_MS        = 100;
   localparam int INT_US       = 100;
   localparam int BIAS_DLY_CYC = BIAS_DLY_MS * CLK_KHZ;
   localparam int RETRY_CYC    = RETRY_MS * CLK_KHZ;
   localparam int DCD_CYC      = DCD_MS * CLK_KHZ;
   localparam int QUAL_CYC     = QUAL_MS * CLK_KHZ;
   localparam int HV_CYC       = HV_MS * CLK_KHZ;
   localparam int INT_CYC      = INT_US * CLK_KHZ / 1000;
   localparam int SET_CYC      = 8;

   typedef struct packed {
      logic uvlo_ok;
      logic sleep_ok;
      logic below_ov;
      logic above_min;
      logic contact;
      logic primary;
      logic secondary;
      logic dp_2p7;
      logic dp_2p0;
      logic dp_1p2;
      logic dm_2p7;
      logic dm_2p0;
      logic dm_1p2;
   } sense_t;

   typedef struct packed {
      logic dp_sink;
      logic dp_src;
      logic dm_sink;
      logic dm_src;
   } dpdm_drv_t;

   typedef enum logic [3:0] {
      S_HIZ   = 4'b0000,
      S_BWAIT = 4'b0001,
      S_QUAL  = 4'b0010,
      S_RETRY = 4'b0011,
      S_DCD   = 4'b0100,
      S_BC12  = 4'b0101,
      S_NSTD  = 4'b0110,
      S_HVHS  = 4'b0111,
      S_VLIM  = 4'b1000,
      S_CONV  = 4'b1001
   } state_t;
endpackage : src_det_pkg

// File: design/src_det.sv
// Our own choices: the Wishbone slave port and the address map.
`timescale 1ns/1ps
module src_det
   import src_det_pkg::*;
#(
   parameter int BIAS_DLY = BIAS_DLY_CYC,
   parameter int RETRY    = RETRY_CYC,
   parameter int DCD      = DCD_CYC,
   parameter int QUAL     = QUAL_CYC,
   parameter int HV_WAIT  = HV_CYC
) (
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   input  wire logic        cyc_i,
   input  wire logic        stb_i,
   input  wire logic        we_i,
   input  wire logic [7:0]  adr_i,
   input  wire logic [3:0]  sel_i,
   input  wire logic [31:0] dat_i,
   output logic      [31:0] dat_o,
   output logic             ack_o,
   input  wire sense_t      sense_i,
   input  wire logic [6:0]  ext_external_current_limit_pin_i,
   output logic             bias_en_o,
   output logic             load_en_o,
   output logic             conv_en_o,
   output dpdm_drv_t        dpdm_o,
   output logic [6:0]       eff_external_current_limit_pin_o,
   output logic [7:0]       vlim_o,
   output logic             int_n_o
);
   ////////////////////////////////////////////////////////////
   sense_t     s1;
   sense_t     s2;
   logic [6:0] e1;
   logic [6:0] e2;
   state_t     state;
   logic [31:0] cnt;
   logic [4:0] ctrl;
   logic [6:0] external_current_limit_pin;
   logic [7:0] vlim;
   logic       good;
   logic       pg;
   logic       port;
   logic [2:0] type_code;
   logic [15:0] int_cnt;
   logic       ev_qual;
   logic       ev_det;
   logic       ev_vlim;
   logic       det_done;
   logic [6:0] det_external_current_limit_pin;
   logic [2:0] det_type;
   logic       bias_ok;
   logic       wr;
   logic       rd_ack;
   logic       hv_req;

   always_ff @(posedge clk_i) begin
      s1 <= sense_i;
      s2 <= s1;
      e1 <= ext_external_current_limit_pin_i;
      e2 <= e1;
   end

   ////////////////////////////////////////////////////////////
   // bias conditions
   assign bias_ok = s2.uvlo_ok & s2.sleep_ok;
   assign hv_req  = ctrl[CTRL_VEND] | ctrl[CTRL_HVP];

   ////////////////////////////////////////////////////////////
   // sequencer
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state <= S_HIZ;
         cnt   <= 32'h0;
      end else if (!bias_ok) begin
         state <= S_HIZ;
         cnt   <= 32'h0;
      end else begin
         cnt <= cnt + 32'h1;
         case (state)
            S_HIZ: begin
               state <= S_BWAIT;
               cnt   <= 32'h0;
            end
            S_BWAIT: begin
               if (cnt == 32'(BIAS_DLY - 1)) begin
                  state <= S_QUAL;
                  cnt   <= 32'h0;
               end
            end
            S_QUAL: begin
               if (cnt == 32'(QUAL - 1)) begin
                  cnt <= 32'h0;
                  if (s2.below_ov && s2.above_min) begin
                     if (ctrl[CTRL_AUTO]) begin
                        state <= S_DCD;
                     end else begin
                        state <= S_VLIM;
                     end
                  end else begin
                     state <= S_RETRY;
                  end
               end
            end
            S_RETRY: begin
               if (cnt == 32'(RETRY - 1)) begin
                  state <= S_QUAL;
                  cnt   <= 32'h0;
               end
            end
            S_DCD: begin
               if (s2.contact) begin
                  state <= S_BC12;
                  cnt   <= 32'h0;
               end else if (cnt == 32'(DCD - 1)) begin
                  state <= S_NSTD;
                  cnt   <= 32'h0;
               end
            end
            S_BC12: begin
               if (cnt == 32'(SET_CYC - 1)) begin
                  cnt <= 32'h0;
                  if (s2.primary && s2.secondary && hv_req) begin
                     state <= S_HVHS;
                  end else begin
                     state <= S_VLIM;
                  end
               end
            end
            S_NSTD: begin
               if (cnt == 32'(SET_CYC - 1)) begin
                  state <= S_VLIM;
                  cnt   <= 32'h0;
               end
            end
            S_HVHS: begin
               if (cnt == 32'(HV_WAIT - 1)) begin
                  state <= S_VLIM;
                  cnt   <= 32'h0;
               end
            end
            S_VLIM: begin
               state <= S_CONV;
               cnt   <= 32'h0;
            end
            S_CONV: begin
               cnt <= 32'h0;
               if (ctrl[CTRL_FORCE] && ctrl[CTRL_AUTO]) begin
                  state <= S_DCD;
               end
            end
            default: begin
               state <= S_HIZ;
               cnt   <= 32'h0;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////
   // detection result
   always_comb begin
      det_done = 1'b0;
      det_external_current_limit_pin = EXTERNAL_CURRENT_LIMIT_PIN_UNK;
      det_type = TYPE_UNK;
      if (bias_ok && cnt == 32'(SET_CYC - 1) && state == S_BC12) begin
         det_done = !(s2.primary && s2.secondary && hv_req);
         if (!s2.primary) begin
            det_external_current_limit_pin = EXTERNAL_CURRENT_LIMIT_PIN_SDP;
            det_type = TYPE_SDP;
         end else if (!s2.secondary) begin
            det_external_current_limit_pin = EXTERNAL_CURRENT_LIMIT_PIN_CDP;
            det_type = TYPE_CDP;
         end else begin
            det_external_current_limit_pin = EXTERNAL_CURRENT_LIMIT_PIN_DCP;
            det_type = TYPE_DCP;
         end
      end else if (bias_ok && cnt == 32'(SET_CYC - 1) && state == S_NSTD) begin
         det_done = 1'b1;
         det_type = TYPE_DIV;
         if (s2.dp_2p7 && s2.dm_2p0) begin
            det_external_current_limit_pin = EXTERNAL_CURRENT_LIMIT_PIN_DIV1;
         end else if (s2.dp_1p2 && s2.dm_1p2) begin
            det_external_current_limit_pin = EXTERNAL_CURRENT_LIMIT_PIN_DIV2;
         end else if (s2.dp_2p0 && s2.dm_2p7) begin
            det_external_current_limit_pin = EXTERNAL_CURRENT_LIMIT_PIN_DIV3;
         end else if (s2.dp_2p7 && s2.dm_2p7) begin
            det_external_current_limit_pin = EXTERNAL_CURRENT_LIMIT_PIN_DIV4;
         end else begin
            det_type = TYPE_UNK;
         end
      end else if (bias_ok && cnt == 32'(HV_WAIT - 1) && state == S_HVHS) begin
         det_done = 1'b1;
         det_external_current_limit_pin = EXTERNAL_CURRENT_LIMIT_PIN_HV;
         det_type = TYPE_HV;
      end
   end

   assign ev_det  = det_done;
   assign ev_qual = bias_ok && state == S_QUAL
                    && cnt == 32'(QUAL - 1) && s2.below_ov && s2.above_min;
   assign ev_vlim = bias_ok && state == S_VLIM;

   ////////////////////////////////////////////////////////////
   // status flags
   always_ff @(posedge clk_i) begin
      if (rst_i || !bias_ok) begin
         good <= 1'b0;
         pg   <= 1'b0;
      end else begin
         if (ev_qual) begin
            good <= 1'b1;
         end
         if (ev_det) begin
            pg <= 1'b1;
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         port      <= 1'b0;
         type_code <= TYPE_NONE;
      end else if (ev_det) begin
         port      <= 1'b1;
         type_code <= det_type;
      end
   end

   ////////////////////////////////////////////////////////////
   // registers
   assign wr = cyc_i & stb_i & we_i & ~ack_o & sel_i[0];

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ctrl <= CTRL_RST;
      end else if (wr && adr_i == ADDR_CTRL) begin
         ctrl <= dat_i[4:0];
      end else if (ev_det || (state == S_CONV && !ctrl[CTRL_AUTO])) begin
         ctrl[CTRL_FORCE] <= 1'b0;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         external_current_limit_pin <= EXTERNAL_CURRENT_LIMIT_PIN_RST;
      end else if (ev_det) begin
         external_current_limit_pin <= det_external_current_limit_pin;
      end else if (wr && adr_i == ADDR_EXTERNAL_CURRENT_LIMIT_PIN) begin
         external_current_limit_pin <= dat_i[6:0];
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         vlim <= VLIM_RST;
      end else if (ctrl[CTRL_ABS]) begin
         if (wr && adr_i == ADDR_VLIM) begin
            if (dat_i[7:0] < VLIM_MIN) begin
               vlim <= VLIM_MIN;
            end else if (dat_i[7:0] > VLIM_MAX) begin
               vlim <= VLIM_MAX;
            end else begin
               vlim <= dat_i[7:0];
            end
         end
      end else if (ev_vlim) begin
         vlim <= (type_code == TYPE_HV) ? VLIM_HI : VLIM_LO;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_o <= 1'b0;
         dat_o <= 32'h0;
      end else begin
         ack_o <= cyc_i & stb_i & ~ack_o;
         dat_o <= 32'h0;
         if (rd_ack) begin
            case (adr_i)
               ADDR_CTRL:   dat_o <= {27'h0, ctrl};
               ADDR_EXTERNAL_CURRENT_LIMIT_PIN:   dat_o <= {25'h0, external_current_limit_pin};
               ADDR_VLIM:   dat_o <= {24'h0, vlim};
               ADDR_STATUS: dat_o <= {20'h0, state, conv_en_o,
                                      bias_en_o, type_code, port,
                                      pg, good};
               ADDR_EFF:    dat_o <= {25'h0, eff_external_current_limit_pin_o};
               default:     dat_o <= 32'h0;
            endcase
         end
      end
   end
   assign rd_ack = cyc_i & stb_i & ~we_i & ~ack_o;

   ////////////////////////////////////////////////////////////
   // outputs
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         bias_en_o  <= 1'b0;
         load_en_o  <= 1'b0;
         conv_en_o  <= 1'b0;
         dpdm_o     <= '0;
         eff_external_current_limit_pin_o <= EXTERNAL_CURRENT_LIMIT_PIN_RST;
         vlim_o     <= VLIM_RST;
      end else begin
         bias_en_o  <= bias_ok && state != S_HIZ
                       && state != S_BWAIT;
         load_en_o  <= bias_ok && state == S_QUAL;
         conv_en_o  <= bias_ok && state == S_CONV;
         dpdm_o     <= '0;
         if (bias_ok && state == S_HVHS) begin
            if (ctrl[CTRL_VEND]) begin
               dpdm_o.dp_sink <= 1'b1;
               dpdm_o.dm_src  <= 1'b1;
            end else if (ctrl[CTRL_HVP]) begin
               dpdm_o.dp_src  <= 1'b1;
               dpdm_o.dm_sink <= 1'b1;
            end
         end
         eff_external_current_limit_pin_o <= (external_current_limit_pin < e2) ? external_current_limit_pin : e2;
         vlim_o     <= vlim;
      end
   end

   ////////////////////////////////////////////////////////////
   // interrupt pulse
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         int_cnt <= 16'h0;
         int_n_o <= 1'b1;
      end else begin
         if (ev_qual || ev_det || ev_vlim) begin
            int_cnt <= 16'(INT_CYC);
         end else if (int_cnt != 16'h0) begin
            int_cnt <= int_cnt - 16'h1;
         end
         int_n_o <= (int_cnt == 16'h0);
      end
   end

   ////////////////////////////////////////////////////////////
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   sequence int_low_s;
      !int_n_o [*8];
   endsequence

   sequence to_conv_s;
      state == S_VLIM ##1 state == S_CONV;
   endsequence

   hiz_bias_a: assert property (!bias_ok |=> ##1 !bias_en_o)
      else $error("bias on while conditions fail");
   bias_dly_a: assert property ($rose(bias_en_o) |->
      $past(state, 2) == S_BWAIT) else $error("bias rose without delay");
   qual_int_a: assert property ($rose(good) |=> int_low_s)
      else $error("no pulse on input good");
   retry_a: assert property (bias_ok && state == S_RETRY
      && cnt == 32'(RETRY - 1) |=> state == S_QUAL)
      else $error("retry did not requalify");
   conv_ord_a: assert property ($rose(conv_en_o) |->
      $past(state, 2) == S_VLIM) else $error("converter out of order");
   det_gate_a: assert property (state == S_DCD |->
      good && bias_en_o) else $error("detect without good");
   auto_off_a: assert property (!ctrl[CTRL_AUTO] && !wr
      && state == S_QUAL |=> $stable(external_current_limit_pin) && state != S_DCD)
      else $error("limit changed with auto off");
   eff_min_a: assert property (##2 eff_external_current_limit_pin_o <=
      $past(external_current_limit_pin, 1) && eff_external_current_limit_pin_o <= $past(e2, 1))
      else $error("effective limit above a source");
   force_clr_a: assert property (ev_det && !wr
      |=> !ctrl[CTRL_FORCE]) else $error("force bit not cleared");
   hs_gate_a: assert property (!hv_req |=>
      dpdm_o == '0) else $error("handshake without enable");
   vlim_int_a: assert property (to_conv_s |->
      ##1 int_low_s) else $error("no pulse on voltage limit");
endmodule : src_det

// File: tb/src_port_model.sv
`timescale 1ns/1ps
// port kinds: 0 sdp, 1 cdp, 2 dcp, 3..6 divider 1..4, 7 unknown
module src_port_model
   import src_det_pkg::*;
(
   input  wire logic       clk_i,
   input  wire logic       attach_i,
   input  wire logic [3:0] supply_i,
   input  wire logic [2:0] mode_i,
   input  wire dpdm_drv_t  dpdm_i,
   output sense_t          sense_o,
   output logic [1:0]      hv_volt_o
);
   logic [1:0] dly = 2'h0;

   // lines settle a few cycles after attach
   always_ff @(posedge clk_i) begin
      dly <= !attach_i ? 2'h0 : (dly == 2'h3 ? dly : dly + 2'h1);
   end

   always_ff @(posedge clk_i) begin
      sense_o <= '0;
      {sense_o.uvlo_ok, sense_o.sleep_ok} <= supply_i[3:2];
      {sense_o.below_ov, sense_o.above_min} <= supply_i[1:0];
      if (attach_i && dly == 2'h3) begin
         sense_o.contact   <= mode_i < 3'h3;
         sense_o.primary   <= mode_i inside {3'h1, 3'h2};
         sense_o.secondary <= mode_i == 3'h2;
         sense_o.dp_2p7    <= mode_i inside {3'h3, 3'h6};
         sense_o.dp_1p2    <= mode_i == 3'h4;
         sense_o.dp_2p0    <= mode_i == 3'h5;
         sense_o.dm_2p0    <= mode_i == 3'h3;
         sense_o.dm_1p2    <= mode_i == 3'h4;
         sense_o.dm_2p7    <= mode_i inside {3'h5, 3'h6};
      end
   end

   // adapter raises its output: 2 = 12 v, 1 = 9 v
   always_ff @(posedge clk_i) begin
      if (!attach_i) begin
         hv_volt_o <= 2'h0;
      end else if (dpdm_i == 4'b1001) begin
         hv_volt_o <= 2'h2;
      end else if (dpdm_i == 4'b0110) begin
         hv_volt_o <= 2'h1;
      end
   end
endmodule : src_port_model

// File: tb/src_det_tb.sv
`timescale 1ns/1ps
module src_det_tb;
   import src_det_pkg::*;
   localparam int BD = 20;
   localparam int RT = 40;
   localparam int IW = INT_CYC + 300;
   localparam logic [2:0] TM [10] = '{3'h0, 3'h1, 3'h2, 3'h2, 3'h2,
      3'h3, 3'h4, 3'h5, 3'h6, 3'h7};
   localparam logic [4:0] TC [10] = '{5'h0d, 5'h0d, 5'h01, 5'h05, 5'h09,
      5'h0d, 5'h0d, 5'h0d, 5'h0d, 5'h0d};
   localparam logic [6:0] TL [10] = '{EXTERNAL_CURRENT_LIMIT_PIN_SDP, EXTERNAL_CURRENT_LIMIT_PIN_CDP, EXTERNAL_CURRENT_LIMIT_PIN_DCP, EXTERNAL_CURRENT_LIMIT_PIN_HV,
      EXTERNAL_CURRENT_LIMIT_PIN_HV, EXTERNAL_CURRENT_LIMIT_PIN_DIV1, EXTERNAL_CURRENT_LIMIT_PIN_DIV2, EXTERNAL_CURRENT_LIMIT_PIN_DIV3, EXTERNAL_CURRENT_LIMIT_PIN_DIV4, EXTERNAL_CURRENT_LIMIT_PIN_UNK};
   localparam logic [2:0] TT [10] = '{TYPE_SDP, TYPE_CDP, TYPE_DCP, TYPE_HV,
      TYPE_HV, TYPE_DIV, TYPE_DIV, TYPE_DIV, TYPE_DIV, TYPE_UNK};
   localparam logic [3:0] TD [10] = '{4'h0, 4'h0, 4'h0, 4'h9, 4'h6,
      4'h0, 4'h0, 4'h0, 4'h0, 4'h0};
   logic        clk_i = 1'b0;
   logic        rst_i = 1'b1;
   logic        cyc_i = 1'b0;
   logic        stb_i = 1'b0;
   logic        we_i = 1'b0;
   logic [7:0]  adr_i = 8'h00;
   logic [3:0]  sel_i = 4'h0;
   logic [31:0] dat_i = 32'h0;
   logic [6:0]  ext_external_current_limit_pin_i = 7'h7f;
   logic [3:0]  supply = 4'h0;
   logic        attach = 1'b0;
   logic [2:0]  mode = 3'h0;
   logic [31:0] dat_o;
   logic        ack_o, bias_en_o, load_en_o, conv_en_o, int_n_o;
   logic [6:0]  eff_external_current_limit_pin_o;
   logic [7:0]  vlim_o;
   logic [1:0]  hv_volt;
   sense_t      sense_i;
   dpdm_drv_t   dpdm_o;
   dpdm_drv_t   last_drv = '0;
   int          fail_count = 0;
   int          checks_done = 0;
   int          int_falls = 0, low_run = 0, max_low = 0, drv_cnt = 0;

   always #12.5 clk_i = ~clk_i;

   src_det #(.BIAS_DLY(BD), .RETRY(RT), .DCD(30), .QUAL(10), .HV_WAIT(20))
   DUT (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i,
      .dat_o, .ack_o, .sense_i, .ext_external_current_limit_pin_i, .bias_en_o, .load_en_o,
      .conv_en_o, .dpdm_o, .eff_external_current_limit_pin_o, .vlim_o, .int_n_o);

   src_port_model port (.clk_i, .attach_i(attach), .supply_i(supply),
      .mode_i(mode), .dpdm_i(dpdm_o), .sense_o(sense_i),
      .hv_volt_o(hv_volt));

   // pulse and line monitors
   always @(posedge clk_i) begin
      low_run <= int_n_o === 1'b0 ? low_run + 1 : 0;
      if (low_run > max_low) max_low <= low_run;
      if (int_n_o === 1'b0 && low_run == 0) int_falls <= int_falls + 1;
      if (dpdm_o !== 4'h0) begin
         drv_cnt <= drv_cnt + 1;
         last_drv <= dpdm_o;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   task automatic end_sim;
      $display("checks %0d mismatches %0d", checks_done, fail_count);
      if (fail_count == 0 && checks_done > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : end_sim

   task automatic chk(input string w, input logic [31:0] e,
                      input logic [31:0] g);
      checks_done++;
      if (g !== e) begin
         fail_count++;
         $display("Error %s expected %h seen %h", w, e, g);
      end
   endtask : chk

   task automatic wait_lvl(ref logic s, input logic v, input int lim,
                           output int n);
      n = 0;
      while (s !== v && n < lim) begin
         @(posedge clk_i);
         n++;
      end
      if (n >= lim) begin
         fail_count++;
         $display("Error wait level expected %b seen %b", v, s);
         end_sim();
      end
   endtask : wait_lvl

   task automatic wb(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] q);
      int n;
      @(posedge clk_i);
      cyc_i <= 1'b1;
      stb_i <= 1'b1;
      we_i <= w;
      adr_i <= a;
      dat_i <= d;
      sel_i <= 4'hf;
      n = 0;
      do begin
         @(posedge clk_i);
         n++;
      end while (ack_o !== 1'b1 && n < 20);
      q = dat_o;
      cyc_i <= 1'b0;
      stb_i <= 1'b0;
      we_i <= 1'b0;
      if (n >= 20) begin
         fail_count++;
         $display("Error bus ack expected 1 seen %b", ack_o);
         end_sim();
      end
   endtask : wb

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      wb(1'b1, a, d, q);
   endtask : wr

   task automatic rd(input logic [7:0] a, input logic [31:0] e,
                     input string w);
      logic [31:0] q;
      wb(1'b0, a, 32'h0, q);
      chk(w, e, q);
   endtask : rd

   task automatic attach_run(input logic [2:0] m, input logic [6:0] e);
      int n;
      mode <= m;
      attach <= 1'b1;
      supply <= 4'hf;
      wait_lvl(bias_en_o, 1'b1, BD + 20, n);
      chk("bias delay", 1, n >= BD);
      chk("conv early", 0, conv_en_o);
      wait_lvl(load_en_o, 1'b1, 5, n);
      wait_lvl(conv_en_o, 1'b1, 400, n);
      chk("eff at start", {25'h0, e}, {25'h0, eff_external_current_limit_pin_o});
   endtask : attach_run

   task automatic detach;
      int n;
      supply <= 4'h0;
      attach <= 1'b0;
      wait_lvl(bias_en_o, 1'b0, 10, n);
      chk("conv off", 0, conv_en_o);
      wait_lvl(int_n_o, 1'b1, IW, n);
   endtask : detach

   ////////////////////////////////////////////////////////////////////////
   task automatic t_reset;
      rd(ADDR_CTRL, {27'h0, CTRL_RST}, "ctrl");
      rd(ADDR_EXTERNAL_CURRENT_LIMIT_PIN, {25'h0, EXTERNAL_CURRENT_LIMIT_PIN_RST}, "external_current_limit_pin");
      rd(ADDR_VLIM, {24'h0, VLIM_RST}, "vlim");
      wr(8'h20, 32'hffff_ffff);
      rd(8'h20, 32'h0, "unmapped");
      chk("int idle", 1, int_n_o);
      chk("bias idle", 0, bias_en_o);
      $display("test reset done");
   endtask : t_reset

   task automatic t_nobias;
      attach <= 1'b1;
      for (int i = 0; i < 2; i++) begin
         supply <= i == 0 ? 4'hb : 4'h7;
         repeat (BD + 30) @(posedge clk_i);
         chk("bias held off", 0, bias_en_o);
      end
      supply <= 4'h0;
      attach <= 1'b0;
      repeat (4) @(posedge clk_i);
      $display("test bias conditions done");
   endtask : t_nobias

   task automatic t_retry;
      int n, f0;
      logic [31:0] q;
      f0 = int_falls;
      attach <= 1'b1;
      supply <= 4'hd;
      wait_lvl(load_en_o, 1'b1, BD + 20, n);
      wait_lvl(load_en_o, 1'b0, 40, n);
      wb(1'b0, ADDR_STATUS, 32'h0, q);
      chk("good on fail", 0, q[ST_GOOD]);
      wait_lvl(load_en_o, 1'b1, RT + 20, n);
      chk("retry gap", 1, n >= RT - 8 && n <= RT + 4);
      supply <= 4'hf;
      wait_lvl(load_en_o, 1'b0, 40, n);
      wb(1'b0, ADDR_STATUS, 32'h0, q);
      chk("good on pass", 1, q[ST_GOOD]);
      chk("qualify int", 1, int_falls > f0);
      detach();
      $display("test retry done");
   endtask : t_retry

   task automatic t_modes;
      int f0, d0;
      for (int i = 0; i < 10; i++) begin
         wr(ADDR_CTRL, {27'h0, TC[i]});
         f0 = int_falls;
         d0 = drv_cnt;
         attach_run(TM[i], TL[i]);
         rd(ADDR_EXTERNAL_CURRENT_LIMIT_PIN, {25'h0, TL[i]}, "external_current_limit_pin");
         rd(ADDR_STATUS, {20'h0, 4'h9, 2'b11, TT[i], 3'b111}, "st");
         chk("vlim", TT[i] == TYPE_HV ? VLIM_HI : VLIM_LO, vlim_o);
         chk("drive", TD[i], drv_cnt == d0 ? 4'h0 : last_drv);
         chk("adapter", TD[i] == 4'h9 ? 2 : TD[i] == 4'h6, hv_volt);
         chk("detect int", 1, int_falls > f0);
         detach();
      end
      $display("test detection modes done");
   endtask : t_modes

   task automatic t_force;
      int n, f0;
      logic [31:0] q;
      wr(ADDR_CTRL, 32'h0d);
      attach_run(3'h1, EXTERNAL_CURRENT_LIMIT_PIN_CDP);
      wait_lvl(int_n_o, 1'b1, IW, n);
      f0 = int_falls;
      mode <= 3'h0;
      wr(ADDR_CTRL, 32'h0f);
      n = 0;
      do begin
         wb(1'b0, ADDR_CTRL, 32'h0, q);
         n++;
      end while (q[CTRL_FORCE] !== 1'b0 && n < 200);
      chk("force cleared", 0, q[CTRL_FORCE]);
      rd(ADDR_EXTERNAL_CURRENT_LIMIT_PIN, {25'h0, EXTERNAL_CURRENT_LIMIT_PIN_SDP}, "forced external_current_limit_pin");
      chk("force int", 1, int_falls > f0);
      detach();
      $display("test force done");
   endtask : t_force

   task automatic t_auto_off;
      int d0;
      logic [31:0] q;
      wr(ADDR_EXTERNAL_CURRENT_LIMIT_PIN, 32'h33);
      wr(ADDR_CTRL, 32'h0c);
      d0 = drv_cnt;
      attach_run(3'h2, 7'h33);
      rd(ADDR_EXTERNAL_CURRENT_LIMIT_PIN, 32'h33, "kept external_current_limit_pin");
      wb(1'b0, ADDR_STATUS, 32'h0, q);
      chk("kept type", TYPE_SDP, q[5:3]);
      chk("kept port", 1, q[ST_PORT]);
      chk("no drive", d0, drv_cnt);
      chk("auto vlim", VLIM_LO, vlim_o);
      detach();
      wr(ADDR_CTRL, 32'h0d);
      $display("test auto off done");
   endtask : t_auto_off

   task automatic t_limits;
      ext_external_current_limit_pin_i <= 7'h14;
      wr(ADDR_EXTERNAL_CURRENT_LIMIT_PIN, 32'h30);
      repeat (4) @(posedge clk_i);
      chk("eff pin", 7'h14, eff_external_current_limit_pin_o);
      rd(ADDR_EFF, 32'h14, "eff reg");
      wr(ADDR_EXTERNAL_CURRENT_LIMIT_PIN, 32'h05);
      repeat (4) @(posedge clk_i);
      chk("eff reg low", 7'h05, eff_external_current_limit_pin_o);
      ext_external_current_limit_pin_i <= 7'h7f;
      wr(ADDR_VLIM, 32'h60);
      rd(ADDR_VLIM, {24'h0, VLIM_LO}, "vlim locked");
      wr(ADDR_CTRL, 32'h1d);
      wr(ADDR_VLIM, 32'h60);
      rd(ADDR_VLIM, 32'h60, "vlim abs");
      chk("vlim pin", 8'h60, vlim_o);
      wr(ADDR_VLIM, 32'hff);
      rd(ADDR_VLIM, {24'h0, VLIM_MAX}, "vlim top");
      wr(ADDR_VLIM, 32'h00);
      rd(ADDR_VLIM, {24'h0, VLIM_MIN}, "vlim bottom");
      wr(ADDR_CTRL, 32'h0d);
      $display("test limits done");
   endtask : t_limits

   initial begin
      repeat (5) @(posedge clk_i);
      rst_i <= 1'b0;
      t_reset();
      t_nobias();
      t_retry();
      t_modes();
      t_force();
      t_auto_off();
      t_limits();
      chk("int width", 1, max_low >= INT_CYC - 2 && max_low <= IW);
      end_sim();
   end
endmodule : src_det_tb
